// file: verilog/hbsr_pkg.sv
// Package of constants for the host bus style and reset front end.
package hbsr_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned RESET_MIN_NS    = 40;
  localparam int unsigned RESET_MIN_CYCLES =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  RESET_CNT_MAX   = 3'(RESET_MIN_CYCLES);

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned ADDR_W          = 3;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam logic [2:0]  ADDR_RESET      = 3'h0;
  localparam logic        TX_IDLE_LEVEL   = 1'b1;

  // ------------------------------------------------------------------
  // Bus access states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    HBSR_IDLE  = 3'b001,
    HBSR_READ  = 3'b010,
    HBSR_WRITE = 3'b100
  } hbsr_state_type;

endpackage

// file: verilog/hbsr_front.sv
// Host bus style select, reset polarity and power-save front end.
//
// Operation
// [R01] Style pin high: reset input active high.
// [R02] Style pin low: reset input active low.
// [R03] Reset of 40 ns defaults everything.
// [R04] During reset: transmit high, receive ignored.
// [R05] Strobe style: chip select with read/write strobes.
// [R06] Direction style: chip select and direction line.
// [R07] Direction style ignores the read strobe.
// [R08] Style chosen only by the select pin.
// [R09] Pump off by pin only while sleeping.
// [R10] Isolation in sleep cuts bus from core.
// [R11] Select high strobe style, low direction.
// [R12] Pump pin active high, needs oscillator stopped.
// [R13] Bus cycles framed by select and strobes.
// [R14] Reset applied early, released on one edge.
`timescale 1ns/100ps

module hbsr_front
  import hbsr_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              bus_style_sel,
  input  wire logic              reset_pin,
  input  wire logic              chip_select_n,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic              rw_dir,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              sleep_state,
  input  wire logic              osc_stopped,
  input  wire logic              pump_autosleep_pin,
  input  wire logic              bus_isolate_request,
  input  wire logic              core_tx,
  input  wire logic              serial_rx,
  output logic                   core_reset,
  output logic                   core_wr_pulse,
  output logic                   core_rd_pulse,
  output logic      [ADDR_W-1:0] core_addr,
  output logic      [DATA_W-1:0] core_wdata,
  output logic                   serial_tx,
  output logic                   core_rx,
  output logic                   pump_enable,
  output logic                   bus_isolated
);

  // ------------------------------------------------------------------
  // Reset polarity and minimum pulse
  // ------------------------------------------------------------------
  logic       reset_active;
  logic [2:0] reset_cnt;
  logic       reset_hold;

  // The pin's meaning flips with the style select, so a style change alone
  // can look like a reset edge; that matches the pin's documented duality.
  assign reset_active = bus_style_sel ? reset_pin : ~reset_pin; // see [R01] see [R02] see [R11]

  // A pulse is accepted only once it has been seen on RESET_MIN_CYCLES clock edges,
  // so glitches caught on fewer edges never disturb the core.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reset_cnt <= 3'h0;
    end else if (!reset_active) begin
      reset_cnt <= 3'h0;
    end else if (reset_cnt != RESET_CNT_MAX) begin
      reset_cnt <= reset_cnt + 3'h1; // see [R03]
    end
  end

  assign reset_hold = srst | (reset_active && (reset_cnt == RESET_CNT_MAX - 3'h1 ||
                                               reset_cnt == RESET_CNT_MAX));

  // Reset is taken into one flip-flop and released on a single clock edge.
  always_ff @(posedge clk_sys) begin
    core_reset <= reset_hold; // see [R14] see [R03]
  end

  // ------------------------------------------------------------------
  // Serial side during reset
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      serial_tx <= TX_IDLE_LEVEL; // see [R04]
    end else begin
      serial_tx <= core_tx;
    end
  end

  // The receive pin is masked to its idle level rather than passed, so a line
  // that toggles through reset cannot leave a false start bit for the core.
  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      core_rx <= TX_IDLE_LEVEL; // see [R04]
    end else begin
      core_rx <= serial_rx;
    end
  end

  // ------------------------------------------------------------------
  // Power: isolation and charge pump
  // ------------------------------------------------------------------
  logic isolate_now;
  logic pump_off_now;
  assign isolate_now  = bus_isolate_request & sleep_state; // see [R10]
  // The pump pin alone never stops the pump: an awake device keeps its
  // drivers powered whatever the pin does.
  assign pump_off_now = pump_autosleep_pin & sleep_state & osc_stopped; // see [R09] see [R12]

  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      bus_isolated <= 1'b0;
    end else begin
      bus_isolated <= isolate_now; // see [R10]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      pump_enable <= 1'b1;
    end else begin
      pump_enable <= ~pump_off_now; // see [R09] see [R12]
    end
  end

  // ------------------------------------------------------------------
  // Bus access decode
  // ------------------------------------------------------------------
  logic           rd_req;
  logic           wr_req;
  hbsr_state_type state;
  hbsr_state_type next_state;

  // Only the style pin picks the decode; the read strobe is never looked at
  // in direction style so a floating pin is harmless.
  always_comb begin
    if (bus_style_sel) begin
      rd_req = ~chip_select_n & ~read_strobe_n & write_strobe_n;  // see [R05] see [R08]
      wr_req = ~chip_select_n & ~write_strobe_n & read_strobe_n;  // see [R05]
    end else begin
      rd_req = ~chip_select_n & rw_dir;                           // see [R06] see [R07]
      wr_req = ~chip_select_n & ~rw_dir;                          // see [R06]
    end
  end

  // Each access is framed by the select and strobe or direction levels; one pulse per
  // frame not begun while isolated, given at its start for reads and at its end for writes.
  always_comb begin
    next_state = state;
    case (state)
      HBSR_IDLE: begin
        if (isolate_now) begin
          next_state = HBSR_IDLE;
        end else if (rd_req) begin
          next_state = HBSR_READ;
        end else if (wr_req) begin
          next_state = HBSR_WRITE;
        end
      end
      HBSR_READ: begin
        if (!rd_req) begin
          next_state = HBSR_IDLE; // see [R13]
        end
      end
      HBSR_WRITE: begin
        if (!wr_req) begin
          next_state = HBSR_IDLE; // see [R13]
        end
      end
      default: begin
        next_state = HBSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      state <= HBSR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // Strobes and captured bus values
  // ------------------------------------------------------------------
  logic rd_start;
  logic wr_end;
  logic capture_now;
  assign rd_start    = (state == HBSR_IDLE) && (next_state == HBSR_READ);  // see [R13]
  assign wr_end      = (state == HBSR_WRITE) && (next_state == HBSR_IDLE); // see [R13]
  assign capture_now = !isolate_now && (rd_req || wr_req);                 // see [R10]

  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      core_rd_pulse <= 1'b0;
    end else begin
      core_rd_pulse <= rd_start;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      core_wr_pulse <= 1'b0;
    end else begin
      core_wr_pulse <= wr_end;
    end
  end

  // Address and data stay frozen between frames and while isolated, so the
  // core sees the last accepted access, never idle bus noise.
  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      core_addr <= ADDR_RESET; // see [R03]
    end else if (capture_now) begin
      core_addr <= bus_addr; // see [R10]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset_hold) begin
      core_wdata <= DATA_RESET; // see [R03]
    end else if (capture_now) begin
      core_wdata <= bus_wdata; // see [R10]
    end
  end

endmodule

// file: tb/hbsr_front_properties.sv
// Checker of reset polarity, bus decode and isolation at the front end ports.
`timescale 1ns/100ps
module hbsr_front_properties
  import hbsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic bus_style_sel,
  input wire logic reset_pin,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic rw_dir,
  input wire logic sleep_state,
  input wire logic bus_isolate_request,
  input wire logic core_reset,
  input wire logic core_rd_pulse,
  input wire logic core_wr_pulse,
  input wire logic serial_tx,
  input wire logic bus_isolated
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Reset pin inactive in either polarity for four edges.
  sequence s_run; (bus_style_sel ^ reset_pin) [*4]; endsequence
  property p_rst_hi; (bus_style_sel && reset_pin) [*4] |=> core_reset; endproperty
  a_rst_hi: assert property (p_rst_hi) else $error("reset high ignored");
  property p_rst_lo; (!bus_style_sel && !reset_pin) [*4] |=> core_reset; endproperty
  a_rst_lo: assert property (p_rst_lo) else $error("reset low ignored");
  property p_rst_off; s_run |=> !core_reset; endproperty
  a_rst_off: assert property (p_rst_off) else $error("reset stuck");
  property p_tx; $rose(core_reset) |-> serial_tx; endproperty
  a_tx: assert property (p_tx) else $error("tx low in reset");
  property p_rd; s_run ##0 (bus_style_sel && !chip_select_n && $fell(read_strobe_n)
    && write_strobe_n && !(bus_isolate_request && sleep_state))
    |=> core_rd_pulse ##1 !core_rd_pulse; endproperty
  a_rd: assert property (p_rd) else $error("strobe read lost");
  property p_dir; s_run ##0 (!bus_style_sel && $fell(chip_select_n) && rw_dir
    && !(bus_isolate_request && sleep_state)) |=> core_rd_pulse; endproperty
  a_dir: assert property (p_dir) else $error("direction read lost");
  property p_nord; !bus_style_sel && !rw_dir |=> !core_rd_pulse; endproperty
  a_nord: assert property (p_nord) else $error("read strobe used");
  property p_iso; s_run |=> bus_isolated == $past(bus_isolate_request && sleep_state);
  endproperty
  a_iso: assert property (p_iso) else $error("isolation wrong");
  property p_wr1; core_wr_pulse |=> !core_wr_pulse; endproperty
  a_wr1: assert property (p_wr1) else $error("write pulse too long");
  c_rd: cover property (core_rd_pulse && bus_style_sel);
  c_dir: cover property (core_rd_pulse && !bus_style_sel);
  c_iso: cover property (bus_isolated);
  c_wr: cover property (core_wr_pulse);
endmodule
bind hbsr_front hbsr_front_properties hbsr_front_properties_i (
  .clk_sys             (clk_sys),
  .srst                (srst),
  .bus_style_sel       (bus_style_sel),
  .reset_pin           (reset_pin),
  .chip_select_n       (chip_select_n),
  .read_strobe_n       (read_strobe_n),
  .write_strobe_n      (write_strobe_n),
  .rw_dir              (rw_dir),
  .sleep_state         (sleep_state),
  .bus_isolate_request (bus_isolate_request),
  .core_reset          (core_reset),
  .core_rd_pulse       (core_rd_pulse),
  .core_wr_pulse       (core_wr_pulse),
  .serial_tx           (serial_tx),
  .bus_isolated        (bus_isolated)
);

// file: tb/hbsr_host.sv
// Host processor model running one parallel bus cycle at a time.
`timescale 1ns/100ps
module hbsr_host
  import hbsr_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              bus_style_sel,
  output logic                   chip_select_n = 1'b1,
  output logic                   read_strobe_n = 1'b1,
  output logic                   write_strobe_n = 1'b1,
  output logic                   rw_dir = 1'b1,
  output logic      [ADDR_W-1:0] bus_addr = '0,
  output logic      [DATA_W-1:0] bus_wdata = '0
);
  // Direction style drives the read strobe low on purpose to show it is ignored.
  task automatic cycle(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input int n);
    @(negedge clk_sys);
    bus_addr = a;
    bus_wdata = d;
    rw_dir = !wr;
    read_strobe_n = bus_style_sel && wr;
    write_strobe_n = !(bus_style_sel && wr);
    chip_select_n = 1'b0;
    repeat (n) @(negedge clk_sys);
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    @(negedge clk_sys);
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
endmodule

// file: tb/hbsr_front_tb.sv
// Self-checking bench for the host bus style and reset front end.
`timescale 1ns/100ps
module hbsr_front_tb;
  import hbsr_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1, bus_style_sel = 1'b1, reset_pin = 1'b0;
  logic sleep_state = 1'b0, osc_stopped = 1'b0;
  logic pump_autosleep_pin = 1'b0, bus_isolate_request = 1'b0;
  logic core_tx = 1'b1, serial_rx = 1'b1, w;
  logic chip_select_n, read_strobe_n, write_strobe_n, rw_dir, core_reset, core_wr_pulse;
  logic core_rd_pulse, serial_tx, core_rx, pump_enable, bus_isolated;
  logic [ADDR_W-1:0] bus_addr, core_addr, a;
  logic [DATA_W-1:0] bus_wdata, core_wdata, d;
  int error_cnt = 0;
  int checked = 0;
  int rd_cnt = 0;
  int rd_mark = 0;
  hbsr_front hbsr_front_i (
    .clk_sys             (clk_sys),
    .srst                (srst),
    .bus_style_sel       (bus_style_sel),
    .reset_pin           (reset_pin),
    .chip_select_n       (chip_select_n),
    .read_strobe_n       (read_strobe_n),
    .write_strobe_n      (write_strobe_n),
    .rw_dir              (rw_dir),
    .bus_addr            (bus_addr),
    .bus_wdata           (bus_wdata),
    .sleep_state         (sleep_state),
    .osc_stopped         (osc_stopped),
    .pump_autosleep_pin  (pump_autosleep_pin),
    .bus_isolate_request (bus_isolate_request),
    .core_tx             (core_tx),
    .serial_rx           (serial_rx),
    .core_reset          (core_reset),
    .core_wr_pulse       (core_wr_pulse),
    .core_rd_pulse       (core_rd_pulse),
    .core_addr           (core_addr),
    .core_wdata          (core_wdata),
    .serial_tx           (serial_tx),
    .core_rx             (core_rx),
    .pump_enable         (pump_enable),
    .bus_isolated        (bus_isolated)
  );
  hbsr_host hbsr_host_i (
    .clk_sys        (clk_sys),
    .bus_style_sel  (bus_style_sel),
    .chip_select_n  (chip_select_n),
    .read_strobe_n  (read_strobe_n),
    .write_strobe_n (write_strobe_n),
    .rw_dir         (rw_dir),
    .bus_addr       (bus_addr),
    .bus_wdata      (bus_wdata)
  );
  always #5 clk_sys = ~clk_sys;
  // Read pulses last one cycle, so they are counted as they pass.
  always @(negedge clk_sys) begin
    if (core_rd_pulse === 1'b1) rd_cnt++;
  end
  always @(negedge clk_sys) begin
    core_tx <= 1'($urandom);
    serial_rx <= 1'($urandom);
  end
  function automatic logic exp_pump(input logic p, input logic s, input logic o);
    return !(p && s && o);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (e !== s) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(79636));
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    for (int s = 1; s >= 0; s--) begin
      bus_style_sel = 1'(s);
      reset_pin = !bus_style_sel;
      repeat (8) @(negedge clk_sys);
      reset_pin = bus_style_sel;
      repeat (5) @(negedge clk_sys);
      chk("core_reset", 8'h01, 8'(core_reset));
      chk("serial_tx", 8'h01, 8'(serial_tx));
      chk("core_rx", 8'h01, 8'(core_rx));
      chk("core_addr", 8'h00, 8'(core_addr));
      reset_pin = !bus_style_sel;
      repeat (4) @(negedge clk_sys);
      chk("core_reset", 8'h00, 8'(core_reset));
      chk("serial_tx", 8'(core_tx), 8'(serial_tx));
      chk("core_rx", 8'(serial_rx), 8'(core_rx));
      for (int i = 0; i < 8; i++) begin
        w = 1'($urandom);
        a = 3'($urandom);
        d = 8'($urandom);
        if (i < 2) begin
          w = 1'(i);
          a = 3'h7;
          d = 8'hff;
        end
        rd_mark = rd_cnt;
        hbsr_host_i.cycle(w, a, d, 1 + i % 3);
        chk("core_addr", 8'(a), 8'(core_addr));
        if (w) chk("core_wdata", d, core_wdata);
        chk("core_wr_pulse", 8'(w), 8'(core_wr_pulse));
        chk("core_rd_pulse", 8'(!w), 8'(rd_cnt - rd_mark));
      end
    end
    for (int k = 0; k < 16; k++) begin
      {sleep_state, osc_stopped, pump_autosleep_pin, bus_isolate_request} = 4'(k);
      repeat (2) @(negedge clk_sys);
      chk("pump_enable", 8'(exp_pump(pump_autosleep_pin, sleep_state, osc_stopped)),
          8'(pump_enable));
      chk("bus_isolated", 8'(bus_isolate_request && sleep_state), 8'(bus_isolated));
    end
    rd_mark = rd_cnt;
    hbsr_host_i.cycle(1'b0, ~a, 8'h5a, 2);
    chk("core_addr", 8'(a), 8'(core_addr));
    chk("core_rd_pulse", 8'h00, 8'(rd_cnt - rd_mark));
    chk("core_wr_pulse", 8'h00, 8'(core_wr_pulse));
    complete_run;
  end
endmodule
